// File: logic/cdq_pkg.sv
// package: constants and types for the charger detect, qualify and led block
`default_nettype none
package cdq_pkg;

  // clock rate
  localparam real CLK_HZ = 25.0e6;

  // debounce times in their own units
  localparam real T_BATT_RISE_MS   = 32.0;   // normal rising edge
  localparam real T_BATT_SLOW_S    = 1.0;    // slow rising edge
  localparam real T_BMIN_FALL_S    = 1.0;    // battery minimum falling edge
  localparam real T_CCCV_MS        = 100.0;  // transition, dual edge
  localparam real T_CURR_MS        = 1.0;    // charge current, dual edge
  localparam real T_DET_MS         = 100.0;  // charger detect, dual edge

  // debounce counts in clock cycles
  localparam int CYC_BATT_RISE = int'(T_BATT_RISE_MS * 1.0e-3 * CLK_HZ);
  localparam int CYC_BATT_SLOW = int'(T_BATT_SLOW_S * CLK_HZ);
  localparam int CYC_BMIN_FALL = int'(T_BMIN_FALL_S * CLK_HZ);
  localparam int CYC_CCCV      = int'(T_CCCV_MS * 1.0e-3 * CLK_HZ);
  localparam int CYC_CURR      = int'(T_CURR_MS * 1.0e-3 * CLK_HZ);
  localparam int CYC_DET       = int'(T_DET_MS * 1.0e-3 * CLK_HZ);
  localparam int CYC_NONE      = 1;      // edge passed after one cycle

  // thermistor window, fractions of the bias level in 32nds
  localparam int TH_DEN  = 32;
  localparam int TH_LOW  = 24;  // cold threshold
  localparam int TH_HIGH = 10;  // hot threshold

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_IMASK = 8'h0c;

  // control register fields
  localparam int CTL_SET_LSB = 0;  // charge_current_setting [3:0]
  localparam int CTL_FORCE   = 4;  // charge_led_force
  localparam int CTL_SWMODE  = 5;  // software controlled charging

  // interrupt bit positions
  localparam int IRQ_CCCV = 0;    // transition_interrupt
  localparam int IRQ_CURR = 1;    // end_current_interrupt
  localparam int IRQ_N    = 2;

  // reset values
  localparam logic [3:0] RST_SETTING = 4'h0;
  localparam logic       RST_FORCE   = 1'b0;
  localparam logic       RST_SWMODE  = 1'b0;
  localparam logic [1:0] RST_IRQ     = 2'h0;

  // lowest two current codes
  localparam logic [3:0] SET_LOW0 = 4'h0;
  localparam logic [3:0] SET_LOW1 = 4'h1;

  // raw comparator outputs from the analog side
  typedef struct packed {
    logic valid;     // charger valid
    logic presence;  // charger presence
    logic current;   // charge_current_threshold
    logic bmin;      // battery_minimum_comparator
    logic bon;       // battery_operating_comparator
    logic cccv;      // cc_cv_transition_comparator
  } cdq_cmp_t;

  // debounced results
  typedef struct packed {
    logic temp_ok;    // thermistor inside window
    logic bon_slow;
    logic bon;
    logic bmin_slow;
    logic bmin;
    logic current;
    logic cccv;
    logic detected;   // charger detected
  } cdq_dbn_t;

endpackage : cdq_pkg
`default_nettype wire

// File: logic/cdq_top.sv
// design: charger detection, comparator debounce, thermistor check and charge led
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

// two-rate debouncer: output follows input after it held stable for the
// rise or fall count; any bounce restarts the count
module cdq_debounce #(
  parameter int RISE_CYC = 1,
  parameter int FALL_CYC = 1
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_in,
  output logic      o_out
);

  logic [31:0] cnt_r;   // cycles the input has differed from the output

  // count while input differs, flip output at the limit
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= 32'h0;
      o_out <= 1'b0;
    end else if (i_in == o_out) begin
      cnt_r <= 32'h0;  // glitch ended: forget it
    end else if (cnt_r >= 32'(((i_in ? RISE_CYC : FALL_CYC)) - 1)) begin
      cnt_r <= 32'h0;
      o_out <= i_in;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

endmodule : cdq_debounce

// Function
// - insertion at low codes needs presence and valid high
// - higher codes: removal on presence and current low
// - low codes or idle: valid low removes
// - detect output decoded per current setting
// - battery comparators normal output, 32 ms rise
// - slow battery outputs filter rise 1.0 s
// - battery minimum falling edge 1.0 s both
// - detect, transition 100 ms; current 1.0 ms
// - debounced crossings raise the two interrupts
// - thermistor thresholds 24/32 and 10/32 bias
// - in range only between thresholds; gates charging
// - led on at charge start, machine controlled
// - end of charge turns led off unless forced
// - force bit 0 auto, 1 on
// - software mode: led follows force bit only
// - automatic led tracks charger enabled status
module cdq_top #(
  parameter int ADC_W         = 10,
  parameter int CYC_BATT_RISE = cdq_pkg::CYC_BATT_RISE,
  parameter int CYC_BATT_SLOW = cdq_pkg::CYC_BATT_SLOW,
  parameter int CYC_BMIN_FALL = cdq_pkg::CYC_BMIN_FALL,
  parameter int CYC_CCCV      = cdq_pkg::CYC_CCCV,
  parameter int CYC_CURR      = cdq_pkg::CYC_CURR,
  parameter int CYC_DET       = cdq_pkg::CYC_DET
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  // wishbone classic slave
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [7:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic      [31:0]      o_wb_dat,
  output logic                  o_wb_ack,
  // analog comparators, asynchronous
  input  wire cdq_pkg::cdq_cmp_t i_cmp,
  // thermistor words from the converter, same clock
  input  wire logic [ADC_W-1:0] i_thermistor_sense_input,
  input  wire logic [ADC_W-1:0] i_thermistor_bias_output,
  // charger state machine, same clock
  input  wire logic             i_charger_enabled_status,
  input  wire logic             i_charging_active,
  // results
  output var cdq_pkg::cdq_dbn_t o_dbn,
  output logic                  o_charge_permit,
  output logic                  o_charge_led_sink,
  output logic                  o_irq
);

  // comparator count
  localparam int NCMP = $bits(cdq_pkg::cdq_cmp_t);

  // register state
  logic [3:0]       setting_r;    // charge_current_setting
  logic             force_r;      // charge_led_force
  logic             swmode_r;     // software controlled charging
  logic [cdq_pkg::IRQ_N-1:0] istat_r;  // sticky interrupt status
  logic [cdq_pkg::IRQ_N-1:0] imask_r;  // interrupt enables
  logic             ack_r;        // bus acknowledge
  logic [31:0]      rdat_r;       // read data

  // synchroniser stages
  logic [NCMP-1:0]  sync1_r;      // first stage, read only by stage two
  logic [NCMP-1:0]  sync2_r;      // safe to use
  cdq_pkg::cdq_cmp_t cs;          // synchronised comparators

  // detection
  logic             det_raw_r;    // undebounced charger present state
  logic             det_nxt;
  logic             low_code;     // setting is one of the two lowest codes

  // debounced values
  logic             db_det;
  logic             db_cccv;
  logic             db_curr;
  logic             db_bmin;
  logic             db_bmin_slow;
  logic             db_bon;
  logic             db_bon_slow;
  logic             cccv_d_r;     // previous debounced transition
  logic             curr_d_r;     // previous debounced current
  logic             ev_cccv;      // crossing events
  logic             ev_curr;

  // thermistor
  logic             temp_ok_r;
  logic             temp_ok_nxt;

  // bus decode
  logic             wb_req;       // new access this cycle
  logic             wb_wr;        // write with low byte lane
  logic [cdq_pkg::IRQ_N-1:0] ev_vec;

  // lowest two current codes
  function automatic logic is_low_code(input logic [3:0] s);
    is_low_code = (s == cdq_pkg::SET_LOW0) || (s == cdq_pkg::SET_LOW1);
  endfunction : is_low_code

  // scaled compare: value * den below ref * num, widened
  function automatic logic below_frac(input logic [ADC_W-1:0] v,
                                      input logic [ADC_W-1:0] r,
                                      input int num);
    logic [ADC_W+7:0] lhs;
    logic [ADC_W+7:0] rhs;
    lhs = (ADC_W+8)'(v) * (ADC_W+8)'(cdq_pkg::TH_DEN);
    rhs = (ADC_W+8)'(r) * (ADC_W+8)'(num);
    below_frac = lhs < rhs;
  endfunction : below_frac

  // two flip-flops on every comparator before any logic looks at it
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= i_cmp;
      sync2_r <= sync1_r;
    end
  end

  assign cs = cdq_pkg::cdq_cmp_t'(sync2_r);
  assign low_code = is_low_code(setting_r);

  // charger present state: set on insertion, cleared on removal causes
  always_comb begin
    det_nxt = det_raw_r;
    if (!det_raw_r) begin
      // insertion at the lowest codes needs both comparators
      det_nxt = cs.presence && cs.valid;
      // at higher codes a live current also counts as a charger
      if (!low_code && (cs.presence || cs.current) && (i_charging_active || cs.valid)) begin
        det_nxt = 1'b1;
      end
    end else if (low_code) begin
      // lowest codes: valid and presence must both stay high
      det_nxt = cs.valid && cs.presence;
    end else if (!cs.presence && !cs.current) begin
      det_nxt = 1'b0;
    end else if (!i_charging_active && !cs.valid) begin
      det_nxt = 1'b0;
    end
  end

  // present state register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      det_raw_r <= 1'b0;
    end else begin
      det_raw_r <= det_nxt;
    end
  end

  // charger detect, both edges 100 ms
  cdq_debounce #(.RISE_CYC(CYC_DET), .FALL_CYC(CYC_DET)) u_db_det (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (det_raw_r),
    .o_out     (db_det)
  );

  // transition comparator, both edges 100 ms
  cdq_debounce #(.RISE_CYC(CYC_CCCV), .FALL_CYC(CYC_CCCV)) u_db_cccv (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.cccv),
    .o_out     (db_cccv)
  );

  // charge current comparator, both edges 1 ms
  cdq_debounce #(.RISE_CYC(CYC_CURR), .FALL_CYC(CYC_CURR)) u_db_curr (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.current),
    .o_out     (db_curr)
  );

  // battery minimum normal: 32 ms rise, 1 s fall
  cdq_debounce #(.RISE_CYC(CYC_BATT_RISE), .FALL_CYC(CYC_BMIN_FALL)) u_db_bmin (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.bmin),
    .o_out     (db_bmin)
  );

  // battery minimum slow: 1 s on both edges
  cdq_debounce #(.RISE_CYC(CYC_BATT_SLOW), .FALL_CYC(CYC_BMIN_FALL)) u_db_bmin_s (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.bmin),
    .o_out     (db_bmin_slow)
  );

  // battery operating normal: 32 ms rise, fall passes at once
  cdq_debounce #(.RISE_CYC(CYC_BATT_RISE), .FALL_CYC(cdq_pkg::CYC_NONE)) u_db_bon (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.bon),
    .o_out     (db_bon)
  );

  // battery operating slow: 1 s rise, fall passes at once
  cdq_debounce #(.RISE_CYC(CYC_BATT_SLOW), .FALL_CYC(cdq_pkg::CYC_NONE)) u_db_bon_s (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_in      (cs.bon),
    .o_out     (db_bon_slow)
  );

  // edge memory for crossing events
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cccv_d_r <= 1'b0;
      curr_d_r <= 1'b0;
    end else begin
      cccv_d_r <= db_cccv;
      curr_d_r <= db_curr;
    end
  end

  // a crossing is either direction of the debounced level
  assign ev_cccv = db_cccv ^ cccv_d_r;
  assign ev_curr = db_curr ^ curr_d_r;

  // thermistor window; a high reading means cold (ntc on the low side)
  always_comb begin
    temp_ok_nxt = below_frac(i_thermistor_sense_input, i_thermistor_bias_output,
                             cdq_pkg::TH_LOW)
                  && !below_frac(i_thermistor_sense_input, i_thermistor_bias_output,
                                 cdq_pkg::TH_HIGH);
  end

  // registered so the result is glitch free
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      temp_ok_r <= 1'b0;
    end else begin
      temp_ok_r <= temp_ok_nxt;
    end
  end

  // charge permit needs a charger and a battery in the window
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_charge_permit <= 1'b0;
    end else begin
      o_charge_permit <= db_det && temp_ok_r;
    end
  end

  // led sink: enabled status in automatic mode, force bit overrides;
  // status drops at fault and end of charge, so the led goes out there
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_charge_led_sink <= 1'b0;
    end else if (swmode_r) begin
      o_charge_led_sink <= force_r;
    end else if (force_r) begin
      o_charge_led_sink <= 1'b1;
    end else begin
      o_charge_led_sink <= i_charger_enabled_status;
    end
  end

  // collected debounced state
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_dbn <= '0;
    end else begin
      o_dbn.detected  <= db_det;
      o_dbn.cccv      <= db_cccv;
      o_dbn.current   <= db_curr;
      o_dbn.bmin      <= db_bmin;
      o_dbn.bmin_slow <= db_bmin_slow;
      o_dbn.bon       <= db_bon;
      o_dbn.bon_slow  <= db_bon_slow;
      o_dbn.temp_ok   <= temp_ok_r;
    end
  end

  // a new access is taken once; ack drops the cycle after
  assign wb_req = i_wb_cyc && i_wb_stb && !ack_r;
  assign wb_wr  = wb_req && i_wb_we && i_wb_sel[0];
  assign ev_vec = {ev_curr, ev_cccv};

  // bus acknowledge, one wait state, unmapped addresses acked too
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

  // control register writes
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      setting_r <= cdq_pkg::RST_SETTING;
      force_r   <= cdq_pkg::RST_FORCE;
      swmode_r  <= cdq_pkg::RST_SWMODE;
    end else if (wb_wr && i_wb_adr == cdq_pkg::OFS_CTRL) begin
      setting_r <= i_wb_dat[cdq_pkg::CTL_SET_LSB +: 4];
      force_r   <= i_wb_dat[cdq_pkg::CTL_FORCE];
      swmode_r  <= i_wb_dat[cdq_pkg::CTL_SWMODE];
    end
  end

  // mask register writes
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      imask_r <= cdq_pkg::RST_IRQ;
    end else if (wb_wr && i_wb_adr == cdq_pkg::OFS_IMASK) begin
      imask_r <= i_wb_dat[cdq_pkg::IRQ_N-1:0];
    end
  end

  // sticky status: write one clears, a new event in the same cycle wins
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      istat_r <= cdq_pkg::RST_IRQ;
    end else if (wb_wr && i_wb_adr == cdq_pkg::OFS_ISTAT) begin
      istat_r <= (istat_r & ~i_wb_dat[cdq_pkg::IRQ_N-1:0]) | ev_vec;
    end else begin
      istat_r <= istat_r | ev_vec;
    end
  end

  // level interrupt while any enabled status bit is set
  assign o_irq = |(istat_r & imask_r);

  // read data captured with the request; unmapped reads give zero
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rdat_r <= 32'h0;
    end else if (wb_req && !i_wb_we) begin
      unique case (i_wb_adr)
        cdq_pkg::OFS_CTRL:  rdat_r <= {26'h0, swmode_r, force_r, setting_r};
        cdq_pkg::OFS_STAT:  rdat_r <= {22'h0, i_charger_enabled_status,
                                       o_charge_led_sink, o_dbn};
        cdq_pkg::OFS_ISTAT: rdat_r <= {30'h0, istat_r};
        cdq_pkg::OFS_IMASK: rdat_r <= {30'h0, imask_r};
        default:            rdat_r <= 32'h0;
      endcase
    end
  end

endmodule : cdq_top
`default_nettype wire

// File: sim/cdq_properties.sv
// checker: port-level timing of the charger detect, qualify and led block
`timescale 1ns/10ps
`default_nettype none
module cdq_properties #(
  parameter int ADC_W = 10, CYC_BATT_RISE = 8, CYC_BATT_SLOW = 40,
  parameter int CYC_BMIN_FALL = 24, CYC_CCCV = 12, CYC_CURR = 10, CYC_DET = 16
) (
  input wire logic              i_clk_sys,
  input wire logic              i_reset,
  input wire logic              i_wb_cyc,
  input wire logic              i_wb_stb,
  input wire logic              i_wb_we,
  input wire logic [7:0]        i_wb_adr,
  input wire logic [3:0]        i_wb_sel,
  input wire logic [31:0]       i_wb_dat,
  input wire logic [31:0]       o_wb_dat,
  input wire logic              o_wb_ack,
  input wire cdq_pkg::cdq_cmp_t i_cmp,
  input wire logic [ADC_W-1:0]  i_thermistor_sense_input,
  input wire logic [ADC_W-1:0]  i_thermistor_bias_output,
  input wire logic              i_charger_enabled_status,
  input wire logic              i_charging_active,
  input wire cdq_pkg::cdq_dbn_t o_dbn,
  input wire logic              o_charge_permit,
  input wire logic              o_charge_led_sink,
  input wire logic              o_irq
);
  wire logic [5:0] cmp_v = i_cmp;  // valid,presence,current,bmin,bon,cccv
  wire logic take = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
  logic [5:0] prev_r;      // levels seen at the last edge
  logic [9:0] stab_r [6];  // edges each level has held, saturating
  logic [5:0] ctrl_r;      // shadow of control
  logic [1:0] mask_r;      // shadow of the mask
  logic       led_exp;     // led level implied now, low in reset
  logic       th_in;       // thermistor inside the window now
  assign led_exp = !i_reset && (ctrl_r[5] ? ctrl_r[4] : (ctrl_r[4] || i_charger_enabled_status));
  assign th_in = !i_reset
    && (int'(i_thermistor_sense_input) * cdq_pkg::TH_DEN < int'(i_thermistor_bias_output) * cdq_pkg::TH_LOW)
    && (int'(i_thermistor_sense_input) * cdq_pkg::TH_DEN >= int'(i_thermistor_bias_output) * cdq_pkg::TH_HIGH);
  // stability counters, one per raw comparator
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      prev_r <= '0;
      for (int i = 0; i < 6; i++) stab_r[i] <= '0;
    end else begin
      prev_r <= cmp_v;
      for (int i = 0; i < 6; i++) stab_r[i] <= (cmp_v[i] != prev_r[i]) ? 10'h0 :
                                                (stab_r[i] == 10'h3ff) ? stab_r[i] : stab_r[i] + 10'h1;
    end
  end
  // register shadows follow accepted writes
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= '0;
      mask_r <= '0;
    end else if (take && i_wb_adr == cdq_pkg::OFS_CTRL) begin
      ctrl_r <= i_wb_dat[5:0];
    end else if (take && i_wb_adr == cdq_pkg::OFS_IMASK) begin
      mask_r <= i_wb_dat[1:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus answer late");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_cur_filter; $changed(o_dbn.current) |-> stab_r[3] >= CYC_CURR; endproperty
  a_cur_filter: assert property (p_cur_filter) else $error("current moved too soon");
  property p_cur_follow; stab_r[3] == CYC_CURR + 8 |-> o_dbn.current == cmp_v[3]; endproperty
  a_cur_follow: assert property (p_cur_follow) else $error("current not followed");
  property p_cccv_filter; $changed(o_dbn.cccv) |-> stab_r[0] >= CYC_CCCV; endproperty
  a_cccv_filter: assert property (p_cccv_filter) else $error("transition moved too soon");
  property p_bmin_rise; $rose(o_dbn.bmin) |-> stab_r[2] >= CYC_BATT_RISE; endproperty
  a_bmin_rise: assert property (p_bmin_rise) else $error("minimum rose too soon");
  property p_bmin_fall; $fell(o_dbn.bmin) || $fell(o_dbn.bmin_slow) |-> stab_r[2] >= CYC_BMIN_FALL; endproperty
  a_bmin_fall: assert property (p_bmin_fall) else $error("minimum fell too soon");
  property p_bon_slow; $rose(o_dbn.bon_slow) |-> stab_r[1] >= CYC_BATT_SLOW; endproperty
  a_bon_slow: assert property (p_bon_slow) else $error("slow operating rose too soon");
  property p_temp; o_dbn.temp_ok == $past(th_in, 2); endproperty
  a_temp: assert property (p_temp) else $error("temperature window wrong");
  property p_led; o_charge_led_sink == $past(led_exp); endproperty
  a_led: assert property (p_led) else $error("led level wrong");
  property p_irq; $changed(o_dbn.cccv) && mask_r[0] |-> ##[0:2] o_irq; endproperty
  a_irq: assert property (p_irq) else $error("transition interrupt missing");
  c_irq: cover property ($rose(o_irq));
  c_det: cover property ($rose(o_dbn.detected));
  c_led: cover property ($rose(o_charge_led_sink));
endmodule : cdq_properties
bind cdq_top cdq_properties #(.ADC_W(ADC_W), .CYC_BATT_RISE(CYC_BATT_RISE), .CYC_BATT_SLOW(CYC_BATT_SLOW),
  .CYC_BMIN_FALL(CYC_BMIN_FALL), .CYC_CCCV(CYC_CCCV), .CYC_CURR(CYC_CURR), .CYC_DET(CYC_DET)) u_props (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_cmp(i_cmp), .i_thermistor_sense_input(i_thermistor_sense_input),
  .i_thermistor_bias_output(i_thermistor_bias_output), .i_charger_enabled_status(i_charger_enabled_status),
  .i_charging_active(i_charging_active), .o_dbn(o_dbn), .o_charge_permit(o_charge_permit),
  .o_charge_led_sink(o_charge_led_sink), .o_irq(o_irq));
`default_nettype wire

// File: sim/cdq_partner.sv
// partner model: analog comparators and thermistor divider feeding the block
`timescale 1ns/10ps
`default_nettype none
module cdq_partner #(
  parameter int ADC_W = 10
) (
  input  wire logic              i_clk_sys,
  output var cdq_pkg::cdq_cmp_t  o_cmp,
  output logic       [ADC_W-1:0] o_sense,
  output logic       [ADC_W-1:0] o_bias
);
  logic [5:0] cmp_r = 6'h00;  // settled from the start, never unknown
  logic [ADC_W-1:0] sense_r = '0, bias_r = '0;
  assign o_cmp = cmp_r;
  assign o_sense = sense_r;
  assign o_bias = bias_r;
  // levels move just after an edge, as slow analog outputs would
  task automatic set_cmp(input logic [5:0] v);
    @(posedge i_clk_sys);
    cmp_r <= v;
  endtask : set_cmp
  // divider code against bias code
  task automatic set_th(input logic [ADC_W-1:0] s, input logic [ADC_W-1:0] b);
    @(posedge i_clk_sys);
    sense_r <= s;
    bias_r <= b;
  endtask : set_th
  // bounce on one comparator, shorter than its filter
  task automatic glitch(input int idx, input int len);
    @(posedge i_clk_sys);
    cmp_r[idx] <= ~cmp_r[idx];
    repeat (len) @(posedge i_clk_sys);
    cmp_r[idx] <= ~cmp_r[idx];
  endtask : glitch
endmodule : cdq_partner
`default_nettype wire

// File: sim/test_cdq_top.sv
// testbench: bus, detection, debounce, interrupt, thermistor and led scenarios
`timescale 1ns/10ps
`default_nettype none
module test_cdq_top;
  localparam int RISE = 8, SLOW = 40, BFALL = 24, CCCV = 12, CURR = 10, DET = 16;
  // setting, valid, presence, current, active, expected detect
  localparam logic [7:0] CTRL = cdq_pkg::OFS_CTRL, STAT = cdq_pkg::OFS_STAT, ISTAT = cdq_pkg::OFS_ISTAT;
  localparam logic [7:0] IMASK = cdq_pkg::OFS_IMASK;
  localparam logic [8:0] DET_TAB [9] = '{9'h01b, 9'h00a, 9'h03f, 9'h036, 9'h08b, 9'h087, 9'h1e8, 9'h092, 9'h1fb};
  localparam logic [9:0] TH_S [4] = '{10'd239, 10'd240, 10'd100, 10'd99};
  logic clk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ces = 1'b0, act = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, irq, permit, led, exp_t;
  logic [9:0]  sense, bias;
  cdq_pkg::cdq_cmp_t cmp;
  cdq_pkg::cdq_dbn_t dbn;
  wire logic [3:0] batt = {dbn.bmin, dbn.bon, dbn.bmin_slow, dbn.bon_slow};
  int n_errors = 0, cmp_count = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cdq_top #(.ADC_W(10), .CYC_BATT_RISE(RISE), .CYC_BATT_SLOW(SLOW), .CYC_BMIN_FALL(BFALL),
    .CYC_CCCV(CCCV), .CYC_CURR(CURR), .CYC_DET(DET)) dut (
    .i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_cmp(cmp),
    .i_thermistor_sense_input(sense), .i_thermistor_bias_output(bias), .i_charger_enabled_status(ces),
    .i_charging_active(act), .o_dbn(dbn), .o_charge_permit(permit), .o_charge_led_sink(led), .o_irq(irq));
  cdq_partner #(.ADC_W(10)) u_part (.i_clk_sys(clk), .o_cmp(cmp), .o_sense(sense), .o_bias(bias));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, sampled at the rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n >= 64) chk(32'h0, 32'h1);
  endtask : wb
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic sm(input logic e, input logic a);
    @(posedge clk);
    {ces, act} <= {e, a};
  endtask : sm
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // watchdog, well beyond the run's length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, IMASK, 32'h0, 4'hf);
    chk(q, 32'h0);
    wb(1'b1, 8'h10, 32'h3f, 4'hf);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    chk(q, 32'h0);  // unmapped place reads zero
    wb(1'b1, CTRL, 32'h13, 4'he);
    wb(1'b0, CTRL, 32'h0, 4'hf);
    chk(q, 32'h0);  // low lane off: write dropped
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, CTRL, {28'h0, DET_TAB[i][8:5]}, 4'h1);
      sm(1'b1, DET_TAB[i][1]);
      u_part.set_cmp({DET_TAB[i][4:2], 3'h0});
      tick(DET + 12);
      chk({31'h0, dbn.detected}, {31'h0, DET_TAB[i][0]});
      wb(1'b0, STAT, 32'h0, 4'hf);
      chk({31'h0, q[0]}, {31'h0, DET_TAB[i][0]});
    end
    wb(1'b1, CTRL, 32'h0, 4'h1);
    u_part.glitch(5, DET / 2);
    tick(DET + 12);
    chk({31'h0, dbn.detected}, 32'h1);
    $display("test detection done");
    u_part.set_cmp(cmp | 6'h06);
    tick(RISE + 8);
    chk({28'h0, batt}, 32'hc);
    tick(SLOW - RISE + 4);
    chk({28'h0, batt}, 32'hf);
    u_part.set_cmp(cmp & 6'h39);
    tick(8);
    chk({28'h0, batt}, 32'ha);
    tick(BFALL + 4);
    chk({28'h0, batt}, 32'h0);
    $display("test battery done");
    wb(1'b1, IMASK, 32'h3, 4'h1);
    wb(1'b1, ISTAT, 32'h3, 4'h1);
    u_part.set_cmp(cmp | 6'h08);
    tick(CURR + 8);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, ISTAT, 32'h0, 4'hf);
    chk(q, 32'h2);
    wb(1'b1, ISTAT, 32'h2, 4'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);  // one written clears the flag
    wb(1'b1, IMASK, 32'h0, 4'h1);
    u_part.set_cmp(cmp | 6'h01);
    tick(CCCV + 8);
    chk({31'h0, irq}, 32'h0);  // masked event stays quiet
    wb(1'b0, ISTAT, 32'h0, 4'hf);
    chk(q, 32'h1);
    wb(1'b1, IMASK, 32'h1, 4'h1);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, ISTAT, 32'h1, 4'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    u_part.set_cmp(cmp & 6'h3e);
    tick(CCCV + 8);
    chk({31'h0, irq}, 32'h1);
    $display("test interrupts done");
    for (int k = 0; k < 4; k++) begin
      u_part.set_th(TH_S[k], 10'd320);
      tick(4);
      exp_t = (TH_S[k] * 32 < 320 * 24) && (TH_S[k] * 32 >= 320 * 10);
      chk({31'h0, dbn.temp_ok}, {31'h0, exp_t});
      chk({31'h0, permit}, {31'h0, exp_t});
    end
    $display("test thermistor done");
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, CTRL, {26'h0, m[2], m[1], 4'h0}, 4'h1);
      sm(m[0], 1'b1);
      tick(4);
      exp_t = m[2] ? m[1] : m[1] | m[0];
      chk({31'h0, led}, {31'h0, exp_t});
      wb(1'b0, STAT, 32'h0, 4'hf);
      chk({31'h0, q[8]}, {31'h0, exp_t});
    end
    $display("test led done");
    print_verdict();
  end
endmodule : test_cdq_top
`default_nettype wire
